//--- verilog/ser_pkg.sv
// Constants, offsets and carriers of the synchronous exception recorder.
// Assumes one core clock and an AHB-Lite register port.
package ser_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CAUSE = 8'h04;
    localparam logic [7:0] OFF_RETADDR = 8'h08;
    localparam logic [7:0] OFF_FAULTADDR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // Field positions
    localparam int CTRL_CU_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_WIDE_BIT = 6;
    localparam int CTRL_KX_BIT = 7;
    localparam int CAUSE_CODE_LSB = 2;
    localparam int CAUSE_CSEL_LSB = 28;
    localparam int CAUSE_DS_BIT = 31;
    // Reset values, vector address and delay-slot step
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [8:0] IRQ_MASK_RST = 9'h000;
    localparam logic [31:0] VECTOR_ADDR = 32'h0000_0100;
    localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
    // Privilege modes
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    // Cause codes
    localparam logic [4:0] CODE_NONE = 5'h00;
    localparam logic [4:0] CODE_FETCH_BUS = 5'h01;
    localparam logic [4:0] CODE_DATA_BUS = 5'h02;
    localparam logic [4:0] CODE_SVC = 5'h03;
    localparam logic [4:0] CODE_HALT = 5'h04;
    localparam logic [4:0] CODE_RESV = 5'h05;
    localparam logic [4:0] CODE_COP = 5'h06;
    localparam logic [4:0] CODE_COND = 5'h07;
    localparam logic [4:0] CODE_WRAP = 5'h08;
    localparam logic [4:0] CODE_FLOAT = 5'h09;
    // Event vector width, one bit per priority level
    localparam int EV_W = 9;
    // Opcodes
    localparam logic [5:0] OP_FUNC_GRP = 6'h00;
    localparam logic [5:0] OP_IMM_GRP = 6'h01;
    localparam logic [5:0] OP_SUM_IMM_W = 6'h08;
    localparam logic [5:0] OP_SUM_IMM_D = 6'h18;
    localparam logic [3:0] OP_COP_HI = 4'h4;
    localparam logic [5:0] FN_SVC = 6'h0C;
    localparam logic [5:0] FN_HALT = 6'h0D;
    localparam logic [5:0] FN_SUM_W = 6'h20;
    localparam logic [5:0] FN_DIFF_W = 6'h22;
    localparam logic [5:0] FN_SUM_D = 6'h2C;
    localparam logic [5:0] FN_DIFF_D = 6'h2E;
    localparam logic [2:0] FN_COND_HI = 3'h6;
    localparam logic [1:0] RT_COND_HI = 2'h1;
    // Defined-code maps, one bit per code value
    localparam logic [63:0] MAJOR_DEFINED = 64'hB7FF_FFFF_0FFF_FFFF;
    localparam logic [63:0] FUNCT_DEFINED = 64'h5F5F_FCFF_FFCF_B3DD;
    localparam logic [31:0] IMMGRP_DEFINED = 32'h000F_5F0F;
    localparam logic [63:0] WIDE_MAJOR = 64'h9090_3080_0F00_0000;
    localparam logic [63:0] WIDE_FUNCT = 64'hDD00_F000_F0D0_0000;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_VECTOR = 1'b1
    } ser_state_t;

    // One instruction offered by the pipeline for retirement
    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [31:0] pc;
        logic [31:0] branchPc;
        logic inDelaySlot;
        logic fetchFault;
        logic dataFault;
        logic floatFault;
        logic [63:0] opA;
        logic [63:0] opB;
    } ser_instr_t;
endpackage : ser_pkg

//--- verilog/ser_check.sv
// Conditional trap evaluation and checked add/subtract overflow.
// Assumes operands are the register values read for the instruction.
`timescale 1ns/100ps
`default_nettype none
module ser_check (
    input wire logic [31:0] word,
    input wire logic [63:0] opA,
    input wire logic [63:0] opB,
    output logic condTrue,
    output logic sumWrap
);
    import ser_pkg::*;
    logic [5:0] major;
    logic [5:0] funct;
    logic [4:0] rt;
    logic isFunc, isImm, useImm, isCond, ge, geu, eq, isSub;
    logic isWordOp, isDwordOp;
    logic [2:0] condSel;
    logic [63:0] rhs, res;
    assign major = word[31:26];
    assign funct = word[5:0];
    assign rt = word[20:16];
    assign isFunc = major == OP_FUNC_GRP;
    assign isImm = major == OP_IMM_GRP;
    assign useImm = isImm | major == OP_SUM_IMM_W | major == OP_SUM_IMM_D;
    assign rhs = useImm ? {{48{word[15]}}, word[15:0]} : opB;
    assign isCond = (isFunc & funct[5:3] == FN_COND_HI)
        | (isImm & rt[4:3] == RT_COND_HI);
    assign condSel = isFunc ? funct[2:0] : rt[2:0];
    assign ge = $signed(opA) >= $signed(rhs);
    assign geu = opA >= rhs;
    assign eq = opA == rhs;
    always_comb begin
        case (condSel)
            3'h0: condTrue = isCond & ge;
            3'h1: condTrue = isCond & geu;
            3'h2: condTrue = isCond & ~ge;
            3'h3: condTrue = isCond & ~geu;
            3'h4: condTrue = isCond & eq;
            3'h6: condTrue = isCond & ~eq;
            default: condTrue = 1'b0;
        endcase
    end
    // Two's-complement wrap on the checked forms only
    assign isSub = isFunc & (funct == FN_DIFF_W | funct == FN_DIFF_D);
    assign isWordOp = major == OP_SUM_IMM_W
        | (isFunc & (funct == FN_SUM_W | funct == FN_DIFF_W));
    assign isDwordOp = major == OP_SUM_IMM_D
        | (isFunc & (funct == FN_SUM_D | funct == FN_DIFF_D));
    assign res = isSub ? opA - rhs : opA + rhs;
    assign sumWrap = (isWordOp & (opA[31] == (rhs[31] ^ isSub))
        & (res[31] != opA[31]))
        | (isDwordOp & (opA[63] == (rhs[63] ^ isSub))
        & (res[63] != opA[63]));
endmodule : ser_check
`default_nettype wire

//--- verilog/ser_decode.sv
// Instruction decode for reserved and coprocessor faults.
// Assumes the word is valid only when the pipeline says so.
`timescale 1ns/100ps
`default_nettype none
module ser_decode (
    input wire logic [31:0] word,
    input wire logic [3:0] copUsable,
    input wire logic userSup,
    input wire logic wideEn,
    output logic isSvc,
    output logic isHalt,
    output logic copFault,
    output logic resvFault
);
    import ser_pkg::*;
    logic [5:0] major;
    logic [5:0] funct;
    logic isFunc, isImm, isCop, wideOp;
    assign major = word[31:26];
    assign funct = word[5:0];
    assign isFunc = major == OP_FUNC_GRP;
    assign isImm = major == OP_IMM_GRP;
    assign isSvc = isFunc & funct == FN_SVC;
    // Bits 25:6 are not looked at
    assign isHalt = isFunc & funct == FN_HALT;
    assign isCop = major[5:2] == OP_COP_HI;
    assign copFault = isCop & ~copUsable[major[1:0]]
        & (major[1:0] != 2'h0 | userSup);
    assign wideOp = WIDE_MAJOR[major] | (isFunc & WIDE_FUNCT[funct]);
    assign resvFault = ~MAJOR_DEFINED[major]
        | (isFunc & ~FUNCT_DEFINED[funct])
        | (isImm & ~IMMGRP_DEFINED[word[20:16]])
        | (wideOp & userSup & ~wideEn);
endmodule : ser_decode
`default_nettype wire

//--- verilog/ser_recorder.sv
// Synchronous exception recorder: detects faults, records cause,
// return address and delay flag, redirects and flushes.
// Assumes the pipeline presents one retiring instruction per cycle.
// Summary of operation
// - every fault here redirects execution to the common vector.
// - return address is faulting pc, or branch pc when in delay slot.
// - service-call instruction raises its exception and records its code.
// - delay flag set only for a delay-slot fault, cleared by any other fault, held between faults.
// - debug-trap instruction raises breakpoint and records its code.
// - debug-trap unused field is ignored by decode.
// - coprocessor unusable raised for unmarked unit; unit 0 only outside kernel.
// - coprocessor fault records code and the referenced coprocessor number.
// - undefined major opcode raises reserved instruction.
// - undefined function or immediate-group minor opcode raises reserved.
// - wide ops in user/supervisor 32-bit mode reserved; kernel runs them, except functions 0x14 and 0x3F, reserved in every mode.
// - a true conditional trap raises trap and records its code.
// - checked add or subtract overflow raises overflow with its code.
// - float unit fault raises float exception; detail stays in float unit.
// - no mask suppresses any of these exceptions.
// - fetch fault address is return address, plus 4 when flagged.
// - data fault instruction is at return address, plus 4 when flagged.
`timescale 1ns/100ps
`default_nettype none
module ser_recorder (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire ser_pkg::ser_instr_t instr,
    output logic commitOk,
    output logic flushYoung,
    output logic redirectValid,
    output logic [31:0] redirectPc,
    output logic irq
);
    import ser_pkg::*;

    ser_state_t stateFf, nxt_state;
    logic [7:0] ctrlFf, nxt_ctrl;
    logic [4:0] causeCodeFf, nxt_causeCode;
    logic delayFlagFf, nxt_delayFlag;
    logic [1:0] copSelFf, nxt_copSel;
    logic [31:0] retAddrFf, nxt_retAddr;
    logic [EV_W-1:0] irqStatFf, nxt_irqStat;
    logic [EV_W-1:0] irqMaskFf, nxt_irqMask;
    logic [31:0] hrdataFf, nxt_hrdata;
    logic wrPendFf;
    logic [7:0] wrAddrFf;

    logic [3:0] copUsable;
    logic [1:0] mode;
    logic userSup, wideEn;
    logic isSvc, isHalt, copFault, resvFault;
    logic condTrue, sumWrap;
    logic live;
    logic [EV_W-1:0] raw, evt;
    logic take;
    logic [4:0] takeCode;
    logic [31:0] faultAddr;
    logic [31:0] causeWord;
    logic [31:0] rdMux;
    logic aphase, rdReq, rdClear, wrCtrl, wrMask;
    logic [7:0] aOff;

    // Control fields steer decode
    assign copUsable = ctrlFf[CTRL_CU_LSB+3:CTRL_CU_LSB];
    assign mode = ctrlFf[CTRL_MODE_LSB+1:CTRL_MODE_LSB];
    assign userSup = mode != MODE_KERNEL;
    assign wideEn = ctrlFf[CTRL_WIDE_BIT];

    ser_decode u_decode (
        .word(instr.word),
        .copUsable(copUsable),
        .userSup(userSup),
        .wideEn(wideEn),
        .isSvc(isSvc),
        .isHalt(isHalt),
        .copFault(copFault),
        .resvFault(resvFault)
    );

    ser_check u_check (
        .word(instr.word),
        .opA(instr.opA),
        .opB(instr.opB),
        .condTrue(condTrue),
        .sumWrap(sumWrap)
    );

    // Nothing is taken in the redirect cycle, that slot is being flushed
    assign live = instr.valid & (stateFf == ST_RUN);

    // Raw conditions; a fetch fault makes the word meaningless
    assign raw[0] = instr.fetchFault;
    assign raw[1] = ~instr.fetchFault & copFault;
    assign raw[2] = ~instr.fetchFault & resvFault;
    assign raw[3] = ~instr.fetchFault & isSvc;
    assign raw[4] = ~instr.fetchFault & isHalt;
    assign raw[5] = ~instr.fetchFault & condTrue;
    assign raw[6] = ~instr.fetchFault & sumWrap;
    assign raw[7] = ~instr.fetchFault & instr.floatFault;
    assign raw[8] = ~instr.fetchFault & instr.dataFault;

    // Priority pick: lowest index wins; no mask term anywhere
    assign evt[0] = live & raw[0];
    generate
        for (genvar i = 1; i < EV_W; i++) begin : g_pri
            assign evt[i] = live & raw[i] & ~|raw[i-1:0];
        end
    endgenerate
    assign take = |evt;

    assign takeCode = evt[0] ? CODE_FETCH_BUS
        : evt[1] ? CODE_COP
        : evt[2] ? CODE_RESV
        : evt[3] ? CODE_SVC
        : evt[4] ? CODE_HALT
        : evt[5] ? CODE_COND
        : evt[6] ? CODE_WRAP
        : evt[7] ? CODE_FLOAT
        : CODE_DATA_BUS;

    // Younger work is squashed the cycle of detection and the next
    assign flushYoung = take | (stateFf == ST_VECTOR);
    assign commitOk = live & ~take;

    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            ST_RUN: begin
                if (take) begin
                    nxt_state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    assign redirectValid = stateFf == ST_VECTOR;
    assign redirectPc = VECTOR_ADDR;

    // Recorded state; floating detail is left in the float unit
    assign nxt_causeCode = take ? takeCode : causeCodeFf;
    assign nxt_delayFlag = take ? instr.inDelaySlot
        : delayFlagFf;
    assign nxt_retAddr = !take ? retAddrFf
        : instr.inDelaySlot ? instr.branchPc : instr.pc;
    assign nxt_copSel = evt[1] ? instr.word[27:26]
        : copSelFf;

    // Handler locates the fault from the record
    assign faultAddr = retAddrFf
        + (delayFlagFf ? SLOT_STEP : 32'h0000_0000);

    assign causeWord = ({31'h0000_0000, delayFlagFf} << CAUSE_DS_BIT)
        | ({30'h0000_0000, copSelFf} << CAUSE_CSEL_LSB)
        | ({27'h0000_0000, causeCodeFf} << CAUSE_CODE_LSB);

    // AHB-Lite slave, zero wait state, always OKAY
    assign aphase = hsel & htrans[1] & hready;
    assign aOff = haddr[7:0];
    assign rdReq = aphase & ~hwrite;
    assign rdClear = rdReq & (aOff == OFF_IRQ_STAT);
    assign wrCtrl = wrPendFf & (wrAddrFf == OFF_CTRL);
    assign wrMask = wrPendFf & (wrAddrFf == OFF_IRQ_MASK);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdataFf;

    assign rdMux = (aOff == OFF_CTRL) ? {24'h00_0000, ctrlFf}
        : (aOff == OFF_CAUSE) ? causeWord
        : (aOff == OFF_RETADDR) ? retAddrFf
        : (aOff == OFF_FAULTADDR) ? faultAddr
        : (aOff == OFF_IRQ_STAT) ? {23'h00_0000, irqStatFf}
        : (aOff == OFF_IRQ_MASK) ? {23'h00_0000, irqMaskFf}
        : 32'h0000_0000;
    assign nxt_hrdata = rdReq ? rdMux : hrdataFf;
    assign nxt_ctrl = wrCtrl ? hwdata[7:0] : ctrlFf;
    assign nxt_irqMask = wrMask ? hwdata[EV_W-1:0] : irqMaskFf;
    // New event beats a clearing read in the same cycle
    assign nxt_irqStat = (rdClear ? {EV_W{1'b0}} : irqStatFf) | evt;
    assign irq = |(irqStatFf & irqMaskFf);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateFf <= ST_RUN;
            causeCodeFf <= CODE_NONE;
            delayFlagFf <= 1'b0;
            copSelFf <= 2'h0;
            retAddrFf <= 32'h0000_0000;
        end else begin
            stateFf <= nxt_state;
            causeCodeFf <= nxt_causeCode;
            delayFlagFf <= nxt_delayFlag;
            copSelFf <= nxt_copSel;
            retAddrFf <= nxt_retAddr;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrlFf <= CTRL_RST;
            irqMaskFf <= IRQ_MASK_RST;
            irqStatFf <= {EV_W{1'b0}};
            hrdataFf <= 32'h0000_0000;
            wrPendFf <= 1'b0;
            wrAddrFf <= 8'h00;
        end else begin
            ctrlFf <= nxt_ctrl;
            irqMaskFf <= nxt_irqMask;
            irqStatFf <= nxt_irqStat;
            hrdataFf <= nxt_hrdata;
            wrPendFf <= aphase & hwrite;
            wrAddrFf <= aOff;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    chk_vector_redirect: assert property (
        take |=> redirectValid && redirectPc == VECTOR_ADDR ##1 !redirectValid)
        else $error("no redirect after fault");
    chk_slot_retaddr: assert property (
        take && instr.inDelaySlot
        |=> retAddrFf == $past(instr.branchPc) && delayFlagFf)
        else $error("delay slot return address wrong");
    chk_svc_code: assert property (
        evt[3] |=> causeCodeFf == CODE_SVC)
        else $error("service call code wrong");
    chk_flag_clear: assert property (
        take && !instr.inDelaySlot
        |=> !delayFlagFf && retAddrFf == $past(instr.pc))
        else $error("delay flag not cleared");
    chk_halt_code: assert property (
        live && !instr.fetchFault && !copFault && !resvFault
        && instr.word[31:26] == OP_FUNC_GRP && instr.word[5:0] == FN_HALT
        |=> causeCodeFf == CODE_HALT)
        else $error("breakpoint not recorded");
    chk_cop_select: assert property (
        evt[1] |=> causeCodeFf == CODE_COP
        && copSelFf == $past(instr.word[27:26]))
        else $error("coprocessor select wrong");
    chk_resv_code: assert property (
        evt[2] |=> causeCodeFf == CODE_RESV)
        else $error("reserved code wrong");
    chk_cond_code: assert property (
        evt[5] |=> causeCodeFf == CODE_COND)
        else $error("trap code wrong");
    chk_wrap_code: assert property (
        evt[6] |=> causeCodeFf == CODE_WRAP)
        else $error("overflow code wrong");
    chk_float_code: assert property (
        evt[7] |=> causeCodeFf == CODE_FLOAT)
        else $error("float code wrong");
    chk_never_masked: assert property (
        live && |raw |-> take && !commitOk)
        else $error("fault not taken");
    chk_fault_addr: assert property (
        take && (!instr.inDelaySlot
        || instr.branchPc + SLOT_STEP == instr.pc)
        |=> faultAddr == $past(instr.pc))
        else $error("fault address not recoverable");
    chk_flush_young: assert property (
        take |=> flushYoung && !commitOk)
        else $error("younger instruction retired");

    // Decode, flag and locating checks
    chk_halt_field: assert property (
        live && !instr.fetchFault && instr.word[31:26] == OP_FUNC_GRP
        && instr.word[5:0] == FN_HALT |-> evt[4])
        else $error("breakpoint depends on unused field");
    chk_cop_raise: assert property (
        live && !instr.fetchFault && instr.word[31:28] == OP_COP_HI
        && !copUsable[instr.word[27:26]]
        && (instr.word[27:26] != 2'h0 || userSup) |-> evt[1])
        else $error("coprocessor fault missed");
    chk_cop_kernel: assert property (
        live && !userSup && instr.word[31:26] == {OP_COP_HI, 2'h0}
        |-> !evt[1])
        else $error("kernel system unit refused");
    chk_imm_resv: assert property (
        live && !instr.fetchFault && instr.word[31:26] == OP_IMM_GRP
        && !IMMGRP_DEFINED[instr.word[20:16]] |-> evt[2])
        else $error("immediate group minor not refused");
    chk_wide_user: assert property (
        live && !instr.fetchFault && userSup && !wideEn
        && WIDE_MAJOR[instr.word[31:26]] |-> evt[2])
        else $error("wide operation not refused");
    chk_wide_kernel: assert property (
        !userSup && WIDE_MAJOR[instr.word[31:26]] |-> !resvFault)
        else $error("wide operation refused in kernel");
    chk_fetch_code: assert property (
        evt[0] |=> causeCodeFf == CODE_FETCH_BUS)
        else $error("fetch fault code wrong");
    chk_fetch_first: assert property (
        live && instr.fetchFault |-> evt[0] && !(|evt[EV_W-1:1]))
        else $error("fetch fault not first");
    chk_data_locate: assert property (
        evt[8] && (!instr.inDelaySlot
        || instr.branchPc + SLOT_STEP == instr.pc)
        |=> causeCodeFf == CODE_DATA_BUS && faultAddr == $past(instr.pc))
        else $error("data fault not locatable");
    chk_no_spurious: assert property (
        !take |=> !redirectValid)
        else $error("redirect without fault");
    chk_commit_clean: assert property (
        live && !(|raw) |-> commitOk && !flushYoung)
        else $error("clean instruction held back");
    chk_event_sticky: assert property (
        take |=> (irqStatFf & $past(evt)) == $past(evt))
        else $error("event not recorded in status");
    chk_svc_flag: assert property (
        evt[3] |=> delayFlagFf == $past(instr.inDelaySlot))
        else $error("service call delay flag wrong");
    chk_halt_flag: assert property (
        evt[4] |=> delayFlagFf == $past(instr.inDelaySlot))
        else $error("breakpoint delay flag wrong");

    cov_svc_slot: cover property (evt[3] && instr.inDelaySlot);
    cov_back_to_back: cover property (take ##2 take);
    cov_irq_raise: cover property (!irq ##1 irq);
    cov_clear_race: cover property (rdClear && take);
    cov_fetch_slot: cover property (evt[0] && instr.inDelaySlot);
endmodule : ser_recorder
`default_nettype wire

//--- testbench/ser_pipe_model.sv
// Pipeline stand-in: offers one retiring instruction at a time.
// Assumes the recorder answers a fault within two cycles.
`timescale 1ns/100ps
`default_nettype none
module ser_pipe_model (
    input wire logic clk_sys,
    output var ser_pkg::ser_instr_t instr
);
    import ser_pkg::*;
    initial instr = '0;
    // Valid for one cycle, then inverted junk so stale fields never match
    task automatic issue(input ser_instr_t i);
        ser_instr_t junk;
        junk = ~i;
        junk.valid = 1'b0;
        @(posedge clk_sys);
        instr <= i;
        @(posedge clk_sys);
        instr <= junk;
        // Gap covers the redirect cycle, where offers would be dropped
        repeat (3) @(posedge clk_sys);
    endtask : issue
    // Handler resumes past the trapping instruction
    function automatic logic [31:0] resume(input logic [31:0] ret);
        return ret + SLOT_STEP;
    endfunction : resume
endmodule : ser_pipe_model
`default_nettype wire

//--- testbench/tb_top.sv
// Bench for the exception recorder: a pipeline model offers faults and
// the records are read back over AHB-Lite. Assumes a zero-wait slave.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ser_pkg::*;
    logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, commitOk;
    logic flushYoung, redirectValid, irq, rdPend, ds;
    logic [31:0] haddr, hwdata, hrdata, redirectPc, seed;
    logic [1:0] htrans;
    logic [2:0] hsize, lo;
    wire logic hready = hreadyout;
    ser_instr_t instr;
    logic [31:0] rdQ[$];
    logic cmQ[$];
    int mismatches, cmpCount, redirects, expRedir;
    logic [2:0] loTab[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};

    ser_recorder i_ser_recorder (.clk_sys, .arst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .instr, .commitOk, .flushYoung, .redirectValid, .redirectPc, .irq);
    ser_pipe_model u_pipe (.clk_sys, .instr);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic testDone;
        if (mismatches == 0 && cmpCount > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : testDone

    task automatic waitReady;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            mismatches++;
            testDone();
        end
    endtask : waitReady

    // Single word transfer; a read notes its expected data first
    task automatic ahb(input logic wr, input logic [7:0] off,
                       input logic [31:0] wd, input logic [31:0] exp);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, off};
        htrans <= 2'h2;
        hwrite <= wr;
        if (!wr) rdQ.push_back(exp);
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
    endtask : ahb

    // Offer one instruction; on a fault read back all three records
    task automatic run(input logic [31:0] w, input logic [2:0] flt,
                       input logic [63:0] a, input logic [63:0] b,
                       input logic [4:0] code, input logic [1:0] csel);
        ser_instr_t i;
        logic [31:0] ret;
        seed = lfsr(seed);
        ds = ~ds;
        i = '0;
        i.valid = 1'b1;
        i.word = w;
        i.pc = {seed[31:2], 2'h0};
        i.branchPc = i.pc - SLOT_STEP;
        i.inDelaySlot = ds;
        {i.fetchFault, i.dataFault, i.floatFault} = flt;
        i.opA = a;
        i.opB = b;
        cmQ.push_back(code == CODE_NONE);
        u_pipe.issue(i);
        if (code != CODE_NONE) begin
            expRedir++;
            ret = ds ? i.branchPc : i.pc;
            ahb(1'b0, OFF_CAUSE, 0, {ds, 1'b0, csel, 21'h0, code, 2'h0});
            ahb(1'b0, OFF_RETADDR, 0, ret);
            ahb(1'b0, OFF_FAULTADDR, 0, ret + (ds ? SLOT_STEP : 0));
            if ((code == CODE_SVC || code == CODE_HALT) && !ds) begin
                i = '0;
                i.valid = 1'b1;
                i.pc = u_pipe.resume(ret);
                cmQ.push_back(1'b1);
                u_pipe.issue(i);
            end
        end
    endtask : run

    // Output watcher: takes the oldest note whenever a result shows
    always @(posedge clk_sys) begin
        if (rdPend && hready && rdQ.size() > 0) begin
            check(hrdata, rdQ.pop_front());
            check(hresp, 1'b0);
        end
        rdPend <= hsel && htrans[1] && !hwrite && hready;
        if (instr.valid && cmQ.size() > 0) begin
            check(commitOk, cmQ[0]);
            check(flushYoung, !cmQ.pop_front());
        end
        if (redirectValid) begin
            check(redirectPc, VECTOR_ADDR);
            redirects++;
        end
    end

    initial begin
        {hsel, hwrite, rdPend, ds, arst_n} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        seed = 32'h3F90;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        ahb(1'b0, OFF_CTRL, 0, {24'h00_0000, CTRL_RST});
        ahb(1'b0, OFF_RETADDR, 0, 0);
        ahb(1'b0, OFF_IRQ_MASK, 0, 0);
        ahb(1'b0, OFF_IRQ_STAT, 0, 0);
        ahb(1'b0, 8'h20, 0, 0);
        ahb(1'b1, OFF_CAUSE, 32'hFFFF_FFFF, 0);
        ahb(1'b0, OFF_CAUSE, 0, 0);
        run({OP_FUNC_GRP, 20'h0, FN_SVC}, 0, 0, 0, CODE_SVC, 0);
        @(negedge clk_sys) check(irq, 0);
        ahb(1'b1, OFF_IRQ_MASK, 32'h0000_0008, 0);
        @(negedge clk_sys) check(irq, 1);
        ahb(1'b0, OFF_IRQ_STAT, 0, 32'h0000_0008);
        @(negedge clk_sys) check(irq, 0);
        // Unused field filled with random bits must not matter
        repeat (4) run({OP_FUNC_GRP, seed[21:2], FN_HALT}, 0, 0, 0,
                       CODE_HALT, 0);
        for (int u = 1; u < 4; u++) begin
            run({OP_COP_HI, u[1:0], 26'h0}, 0, 0, 0, CODE_COP, u[1:0]);
        end
        ahb(1'b1, OFF_CTRL, 32'h0000_0010, 0);
        run({OP_COP_HI, 2'h0, 26'h0}, 0, 0, 0, CODE_COP, 0);
        run({OP_SUM_IMM_D, 26'h1}, 0, 1, 0, CODE_RESV, 0);
        ahb(1'b1, OFF_CTRL, 32'h0000_0050, 0);
        run({OP_SUM_IMM_D, 26'h1}, 0, 1, 0, CODE_NONE, 0);
        ahb(1'b1, OFF_CTRL, 32'h0000_0080, 0);
        run({OP_SUM_IMM_D, 26'h1}, 0, 1, 0, CODE_NONE, 0);
        run({OP_COP_HI, 2'h0, 26'h0}, 0, 0, 0, CODE_NONE, 0);
        ahb(1'b1, OFF_CTRL, 32'h0000_0001, 0);
        run({6'h1C, 26'h0}, 0, 0, 0, CODE_RESV, 0);
        run({OP_FUNC_GRP, 20'h0, 6'h01}, 0, 0, 0, CODE_RESV, 0);
        run({OP_IMM_GRP, 10'h4, 16'h0}, 0, 0, 0, CODE_RESV, 0);
        for (int k = 0; k < 12; k++) begin
            lo = loTab[k % 6];
            run((k < 6) ? {OP_FUNC_GRP, 20'h0, FN_COND_HI, lo}
                : {OP_IMM_GRP, 5'h0, RT_COND_HI, lo, 16'h0005}, 0,
                (lo inside {3'h2, 3'h3, 3'h6}) ? 64'h3 : 64'h5, 64'h5,
                CODE_COND, 0);
        end
        run({OP_FUNC_GRP, 20'h0, FN_COND_HI, 3'h4}, 0, 3, 5, CODE_NONE, 0);
        run({OP_FUNC_GRP, 20'h0, FN_SUM_W}, 0, 64'h7FFF_FFFF, 1, CODE_WRAP, 0);
        run({OP_FUNC_GRP, 20'h0, FN_SUM_W}, 0, 64'h7FFF_FFFE, 1, CODE_NONE, 0);
        run({OP_FUNC_GRP, 20'h0, FN_DIFF_W}, 0, 64'hFFFF_FFFF_8000_0000, 1,
            CODE_WRAP, 0);
        run({OP_FUNC_GRP, 20'h0, FN_SUM_D}, 0, 64'h7FFF_FFFF_FFFF_FFFF, 1,
            CODE_WRAP, 0);
        run({OP_FUNC_GRP, 20'h0, FN_DIFF_D}, 0, 64'h8000_0000_0000_0000, 1,
            CODE_WRAP, 0);
        run({OP_SUM_IMM_W, 26'h1}, 0, 64'h7FFF_FFFF, 0, CODE_WRAP, 0);
        run({OP_SUM_IMM_D, 26'h1}, 0, 64'h7FFF_FFFF_FFFF_FFFF, 0,
            CODE_WRAP, 0);
        run(0, 3'h1, 0, 0, CODE_FLOAT, 0);
        repeat (2) run({OP_FUNC_GRP, 20'h0, FN_SVC}, 3'h4, 0, 0,
                       CODE_FETCH_BUS, 0);
        repeat (2) run(0, 3'h2, 0, 0, CODE_DATA_BUS, 0);
        check(redirects, expRedir);
        testDone();
    end
endmodule : tb_top
`default_nettype wire
